// [hdl/ddsr_top.sv]
// tuning and phase word registers, serial word decode and phase accumulator
//
// Contract
// - two 28-bit tuning words; the selected one sets output frequency fclk*word/2^28
// - two 12-bit phase words; the selected one is added to accumulator output
// - source bit 1 lets pins pick words, source bit 0 lets control bits pick
// - active phase selector 0 picks phase word a, 1 picks phase word b
// - select pins are sampled; a change at the edge may land a cycle off
// - address 01 loads tuning word a, 10 tuning word b, low 14 bits data
// - full-width mode: two writes to one address, low half first, high second
// - half mode: each write updates one half, half select bit picks which
// - address 00 is a control word carrying full-width and half select bits
// - address 11 loads a phase word; bit 13 picks which, 12 ignored
// - reset holds accumulator at midscale, leaves all words and control untouched
// - waveform appears eight or nine clocks after reset is released; the code takes thirteen after the reset pin is released
// - source bit 0: reset bit drives reset; 1: reset pin drives it
// - reset pin asserts at once; its release is sampled by the clock
`timescale 1ns/1ns

module ddsr_top
	import ddsr_pkg::*;
#(
	parameter int OUT_LATENCY = `DDSR_OUT_LATENCY
) (
	input wire logic clk, // master clock, 100 MHz
	input wire logic reset, // asynchronous reset, active high
	input wire ddsr_word_t word_in, // 16-bit word with valid strobe
	input wire logic tuning_select_pin, // external tuning word select
	input wire logic phase_select_pin, // external phase word select
	input wire logic reset_pin, // external functional reset
	output logic [`DDSR_PHASE_W-1:0] out_phase, // phase to the converter
	output logic out_active, // converter output carries the waveform
	output logic out_tuning_sel, // tuning word in use
	output logic out_phase_sel, // phase word in use
	output logic out_hold, // accumulator held at midscale
	output logic out_load_pending // low half waiting for its high half
);

	logic [`DDSR_ACC_W-1:0] tuning_reg [`DDSR_CHANNELS];
	logic [`DDSR_PHASE_W-1:0] phase_reg [`DDSR_CHANNELS];
	ddsr_ctrl_t ctrl_reg;
	ddsr_load_t load_reg;
	ddsr_load_t load_next;
	logic [`DDSR_HALF_W-1:0] pend_low_reg;
	logic pend_index_reg;
	logic [2:0] pin_level;
	logic pin_hold_reg;
	logic hold;
	logic tsel_reg;
	logic psel_reg;
	logic hold_reg;
	logic [`DDSR_ACC_W-1:0] acc_reg;
	logic [`DDSR_PHASE_W-1:0] phase_sum;
	logic [`DDSR_PHASE_W-1:0] pipe_reg [OUT_LATENCY];
	logic [OUT_LATENCY-1:0] active_reg;
	logic [1:0] addr;
	logic [`DDSR_HALF_W-1:0] payload;
	logic is_tune;
	logic tune_index;
	logic commit;

	// select pins and reset pin pass the synchroniser
	ddsr_sync #(
		.WIDTH(3)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.pin_async({reset_pin, phase_select_pin, tuning_select_pin}),
		.level(pin_level)
	);

	assign addr = word_in.data[`DDSR_ADDR_HI:`DDSR_ADDR_LO];
	assign payload = word_in.data[`DDSR_HALF_W-1:0];
	assign is_tune = word_in.valid &&
		(addr == `DDSR_ADDR_TUNE_A || addr == `DDSR_ADDR_TUNE_B);
	assign tune_index = addr[1];
	assign commit = (load_reg == ddsr_load_have_low) && (pend_index_reg == tune_index);

	// control word decode
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_reg <= '0;
		end else if (word_in.valid && addr == `DDSR_ADDR_CTRL) begin
			ctrl_reg.full_width_load_bit <= word_in.data[`DDSR_BIT_FULL_WIDTH];
			ctrl_reg.half_select_bit <= word_in.data[`DDSR_BIT_HALF_SEL];
			ctrl_reg.tuning_select_bit <= word_in.data[`DDSR_BIT_TUNING_SEL];
			ctrl_reg.phase_select_bit <= word_in.data[`DDSR_BIT_PHASE_SEL];
			ctrl_reg.control_source_bit <= word_in.data[`DDSR_BIT_SOURCE];
			ctrl_reg.soft_reset_bit <= word_in.data[`DDSR_BIT_SOFT_RESET];
		end
	end

	// tracks the first half of a full-width load
	always_comb begin
		load_next = load_reg;
		case (load_reg)
			ddsr_load_idle: begin
				if (is_tune && ctrl_reg.full_width_load_bit) begin
					load_next = ddsr_load_have_low;
				end
			end
			ddsr_load_have_low: begin
				if (word_in.valid && addr == `DDSR_ADDR_CTRL) begin
					load_next = ddsr_load_idle;
				end else if (is_tune && commit) begin
					load_next = ddsr_load_idle;
				end else if (is_tune && !ctrl_reg.full_width_load_bit) begin
					load_next = ddsr_load_idle;
				end
			end
			default: begin
				load_next = ddsr_load_idle;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			load_reg <= ddsr_load_idle;
		end else begin
			load_reg <= load_next;
		end
	end

	// a fresh low half restarts the pairing, even for the other address
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pend_low_reg <= `DDSR_HALF_RESET;
			pend_index_reg <= 1'b0;
		end else if (is_tune && ctrl_reg.full_width_load_bit && !commit) begin
			pend_low_reg <= payload;
			pend_index_reg <= tune_index;
		end
	end

	generate
		for (genvar i = 0; i < `DDSR_CHANNELS; i++) begin : g_words
			logic tune_hit;
			logic phase_hit;

			assign tune_hit = is_tune && (tune_index == 1'(i));
			assign phase_hit = word_in.valid && addr == `DDSR_ADDR_PHASE &&
				word_in.data[`DDSR_BIT_PHASE_WORD] == 1'(i);

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					tuning_reg[i] <= `DDSR_TUNING_RESET;
				end else if (tune_hit) begin
					if (ctrl_reg.full_width_load_bit) begin
						if (commit) begin
							tuning_reg[i] <= {payload, pend_low_reg};
						end
					end else if (ctrl_reg.half_select_bit) begin
						tuning_reg[i][`DDSR_ACC_W-1:`DDSR_HALF_W] <= payload;
					end else begin
						tuning_reg[i][`DDSR_HALF_W-1:0] <= payload;
					end
				end
			end

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					phase_reg[i] <= `DDSR_PHASE_RESET;
				end else if (phase_hit) begin
					phase_reg[i] <= word_in.data[`DDSR_PHASE_W-1:0];
				end
			end
		end
	endgenerate

	// pin reset sets at once and releases only on the filtered low level
	always_ff @(posedge clk or posedge reset or posedge reset_pin) begin
		if (reset || reset_pin) begin
			pin_hold_reg <= 1'b1;
		end else begin
			pin_hold_reg <= pin_level[2];
		end
	end

	assign hold = ctrl_reg.control_source_bit ? pin_hold_reg : ctrl_reg.soft_reset_bit;

	// word selection follows pins or control bits
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tsel_reg <= 1'b0;
			psel_reg <= 1'b0;
		end else if (ctrl_reg.control_source_bit) begin
			tsel_reg <= pin_level[0];
			psel_reg <= pin_level[1];
		end else begin
			tsel_reg <= ctrl_reg.tuning_select_bit;
			psel_reg <= ctrl_reg.phase_select_bit;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hold_reg <= 1'b1;
		end else begin
			hold_reg <= hold;
		end
	end

	// accumulator steps by the selected tuning word each clock it is not held
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_reg <= '0;
		end else if (hold) begin
			acc_reg <= '0;
		end else begin
			acc_reg <= acc_reg + tuning_reg[tsel_reg];
		end
	end

	assign phase_sum = acc_reg[`DDSR_ACC_W-1:`DDSR_ACC_W-`DDSR_PHASE_W] +
		phase_reg[psel_reg];

	// output pipeline sets the delay from release to waveform
	generate
		for (genvar s = 0; s < OUT_LATENCY; s++) begin : g_pipe
			logic [`DDSR_PHASE_W-1:0] stage_in;
			logic active_in;

			if (s == 0) begin : g_first
				assign stage_in = phase_sum;
				assign active_in = 1'b1;
			end else begin : g_rest
				assign stage_in = pipe_reg[s-1];
				assign active_in = active_reg[s-1];
			end

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					pipe_reg[s] <= `DDSR_MIDSCALE;
					active_reg[s] <= 1'b0;
				end else if (hold) begin
					pipe_reg[s] <= `DDSR_MIDSCALE;
					active_reg[s] <= 1'b0;
				end else begin
					pipe_reg[s] <= stage_in;
					active_reg[s] <= active_in;
				end
			end
		end
	endgenerate

	assign out_phase = pipe_reg[OUT_LATENCY-1];
	assign out_active = active_reg[OUT_LATENCY-1];
	assign out_tuning_sel = tsel_reg;
	assign out_phase_sel = psel_reg;
	assign out_hold = hold_reg;
	assign out_load_pending = (load_reg == ddsr_load_have_low);

endmodule

// [hdl/ddsr_defines.svh]
// constants for the tuning and phase register load block
`ifndef DDSR_DEFINES_SVH
`define DDSR_DEFINES_SVH

`define DDSR_WORD_W 16
`define DDSR_ACC_W 28
`define DDSR_HALF_W 14
`define DDSR_PHASE_W 12
`define DDSR_CHANNELS 2

`define DDSR_ADDR_HI 15
`define DDSR_ADDR_LO 14
`define DDSR_ADDR_CTRL 2'h0
`define DDSR_ADDR_TUNE_A 2'h1
`define DDSR_ADDR_TUNE_B 2'h2
`define DDSR_ADDR_PHASE 2'h3

`define DDSR_BIT_FULL_WIDTH 13
`define DDSR_BIT_HALF_SEL 12
`define DDSR_BIT_TUNING_SEL 11
`define DDSR_BIT_PHASE_SEL 10
`define DDSR_BIT_SOURCE 9
`define DDSR_BIT_SOFT_RESET 8
`define DDSR_BIT_PHASE_WORD 13

`define DDSR_TUNING_RESET 28'h0000000
`define DDSR_PHASE_RESET 12'h000
`define DDSR_HALF_RESET 14'h0000
`define DDSR_MIDSCALE 12'h000
`define DDSR_OUT_LATENCY 8

`endif

// [hdl/ddsr_pkg.sv]
// types shared by the tuning and phase register load block
`include "ddsr_defines.svh"

package ddsr_pkg;

	typedef struct packed {
		logic valid;
		logic [`DDSR_WORD_W-1:0] data;
	} ddsr_word_t;

	typedef struct packed {
		logic full_width_load_bit;
		logic half_select_bit;
		logic tuning_select_bit;
		logic phase_select_bit;
		logic control_source_bit;
		logic soft_reset_bit;
	} ddsr_ctrl_t;

	typedef enum logic {
		ddsr_load_idle,
		ddsr_load_have_low
	} ddsr_load_t;

endpackage

// [hdl/ddsr_sync.sv]
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns

module ddsr_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk, // master clock
	input wire logic reset, // asynchronous reset, active high
	input wire logic [WIDTH-1:0] pin_async, // raw pin levels
	output logic [WIDTH-1:0] level // filtered levels
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] agree;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
		end else begin
			stage1_reg <= pin_async;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	assign agree = ~(stage2_reg ^ stage3_reg);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			level_reg <= '0;
		end else begin
			level_reg <= (agree & stage3_reg) | (~agree & level_reg);
		end
	end

	assign level = level_reg;

endmodule

// [verif/ddsr_host.sv]
// host model handing serial words to the block
`timescale 1ns/1ns

module ddsr_host
	import ddsr_pkg::*;
(
	input wire logic clk, // master clock
	input wire logic reset, // async reset
	input wire logic slow, // idle cycle after each word
	output ddsr_word_t word_in // word to the block
);
	logic [15:0] q[$];
	logic gap;
	task automatic put(input logic [15:0] w);
		q.push_back(w);
	endtask
	// idle cycles invert the previous cycle's data, so a run of idle cycles alternates the inverse and the last word
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			word_in <= '0;
			gap <= 1'b0;
		end else if (q.size() > 0 && !gap) begin
			word_in <= {1'b1, q.pop_front()};
			gap <= slow;
		end else begin
			word_in <= {1'b0, ~word_in.data};
			gap <= 1'b0;
		end
	end
endmodule

// [verif/ddsr_chk.sv]
// assertions on the ports of the register load block
`timescale 1ns/1ns

module ddsr_chk
	import ddsr_pkg::*;
(
	input wire logic clk, // master clock
	input wire logic reset, // async reset
	input wire ddsr_word_t word_in, // word port
	input wire logic tuning_select_pin, // tuning pin
	input wire logic phase_select_pin, // phase pin
	input wire logic reset_pin, // reset pin
	input wire logic [`DDSR_PHASE_W-1:0] out_phase, // phase out
	input wire logic out_active, // waveform present
	input wire logic out_tuning_sel, // tuning word in use
	input wire logic out_phase_sel, // phase word in use
	input wire logic out_hold, // held at midscale
	input wire logic out_load_pending // low half stored
);
	logic src_reg, tsel_reg, psel_reg, fw_reg;
	wire ctl = word_in.valid && word_in.data[15:14] == 2'h0;
	wire tun = word_in.valid && ^word_in.data[15:14];
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{src_reg, tsel_reg, psel_reg, fw_reg} <= 4'h0;
		end else if (ctl) begin
			src_reg <= word_in.data[9];
			tsel_reg <= word_in.data[11];
			psel_reg <= word_in.data[10];
			fw_reg <= word_in.data[13];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_sw;
		ctl && !word_in.data[9];
	endsequence
	property p_tsel_sw; s_sw |=> ##1 out_tuning_sel == tsel_reg; endproperty
	a_tsel_sw: assert property (p_tsel_sw) else $error("tuning select bit");
	property p_psel_sw; s_sw |=> ##1 out_phase_sel == psel_reg; endproperty
	a_psel_sw: assert property (p_psel_sw) else $error("phase select bit");
	property p_tsel_pin;
		(src_reg && $stable(tuning_select_pin))[*7] |-> out_tuning_sel == tuning_select_pin;
	endproperty
	a_tsel_pin: assert property (p_tsel_pin) else $error("tuning select pin");
	property p_psel_pin;
		(src_reg && $stable(phase_select_pin))[*7] |-> out_phase_sel == phase_select_pin;
	endproperty
	a_psel_pin: assert property (p_psel_pin) else $error("phase select pin");
	property p_soft; s_sw ##0 word_in.data[8] |=> ##1 out_hold; endproperty
	a_soft: assert property (p_soft) else $error("reset bit ignored");
	property p_pin_hold; src_reg && $rose(reset_pin) |-> ##[0:2] out_hold; endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("reset pin slow");
	property p_held; out_hold |-> !out_active && out_phase == 12'h000; endproperty
	a_held: assert property (p_held) else $error("output not midscale");
	property p_lat;
		$fell(out_hold) && !$past(reset) && !$past(reset, 2) |->
			!out_active [*6] ##[1:2] out_active;
	endproperty
	a_lat: assert property (p_lat) else $error("output latency");
	property p_pend; tun && fw_reg && !out_load_pending |=> out_load_pending; endproperty
	a_pend: assert property (p_pend) else $error("low half not held");
	property p_pair;
		tun && fw_reg && out_load_pending && $past(tun)
			&& word_in.data[15:14] == $past(word_in.data[15:14]) |=> !out_load_pending;
	endproperty
	a_pair: assert property (p_pair) else $error("pair not committed");
	property p_half; tun && !fw_reg |=> !out_load_pending; endproperty
	a_half: assert property (p_half) else $error("half write pending");
endmodule

bind ddsr_top ddsr_chk u_chk (.clk(clk), .reset(reset), .word_in(word_in),
	.tuning_select_pin(tuning_select_pin), .phase_select_pin(phase_select_pin),
	.reset_pin(reset_pin), .out_phase(out_phase), .out_active(out_active),
	.out_tuning_sel(out_tuning_sel), .out_phase_sel(out_phase_sel),
	.out_hold(out_hold), .out_load_pending(out_load_pending));

// [verif/test_dds_tuning_phase_register_load.sv]
// self-checking testbench for the tuning and phase register load block
`timescale 1ns/1ns

module test_dds_tuning_phase_register_load;
	import ddsr_pkg::*;
	typedef struct packed {
		logic [1:0] kind;
		logic [11:0] val;
	} ddsr_note_t;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic tpin = 1'b0; // held steady while bits select
	logic ppin = 1'b0; // held steady while bits select
	logic rpin = 1'b0;
	logic slow = 1'b1;
	ddsr_word_t word_in;
	logic [11:0] out_phase, prev_phase, ph_a, ph_b, d_a, d_b;
	logic out_active, out_tuning_sel, out_phase_sel, out_hold, out_load_pending;
	ddsr_note_t notes[$];
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	ddsr_host host (.clk(clk), .reset(reset), .slow(slow), .word_in(word_in));
	ddsr_top uut (.clk(clk), .reset(reset), .word_in(word_in), .tuning_select_pin(tpin),
		.phase_select_pin(ppin), .reset_pin(rpin), .out_phase(out_phase),
		.out_active(out_active), .out_tuning_sel(out_tuning_sel),
		.out_phase_sel(out_phase_sel), .out_hold(out_hold),
		.out_load_pending(out_load_pending));
	task automatic summarize();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [15:0] w);
		host.put(w);
		while (host.q.size() > 0) @(posedge clk);
	endtask
	// settle past the output pipeline, then note the expectation
	task automatic note(input logic [1:0] k, input logic [11:0] v);
		repeat (14) @(posedge clk);
		notes.push_back({k, v});
	endtask
	always @(negedge clk) begin
		ddsr_note_t n;
		cycles++;
		if (cycles > 3000) begin
			mismatches++;
			summarize();
		end else begin
			if (notes.size() > 0) begin
				n = notes.pop_front();
				case (n.kind)
					2'h0: chk(out_phase, n.val);
					2'h1: chk(out_phase - prev_phase, n.val);
					default: chk({11'h000, out_hold}, n.val);
				endcase
			end
			prev_phase = out_phase;
		end
	end
	initial begin
		void'($urandom(54377));
		ph_a = $urandom();
		ph_b = $urandom();
		d_a = $urandom();
		d_b = $urandom();
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		send(16'h0100);
		send({4'hc, ph_a});
		send({4'hf, ph_b});
		send(16'h0000);
		note(2'h0, ph_a);
		send(16'h0400);
		note(2'h0, ph_b);
		send(16'h0600);
		note(2'h0, ph_a);
		ppin <= 1'b1;
		note(2'h0, ph_b);
		rpin <= 1'b1;
		note(2'h2, 12'h001);
		note(2'h0, 12'h000);
		rpin <= 1'b0;
		slow <= 1'b0;
		send(16'h2100);
		send(16'h4000);
		send({2'h1, d_a, 2'h0});
		send(16'h1100);
		send({2'h2, d_b, 2'h0});
		send(16'h0000);
		note(2'h1, d_a);
		send(16'h0800);
		note(2'h1, d_b);
		send(16'h0200);
		note(2'h1, d_a);
		tpin <= 1'b1;
		note(2'h1, d_b);
		repeat (3) @(posedge clk);
		summarize();
	end
endmodule
